// File: cswc_pkg.sv
// Constants, register map and state encodings of the CAN sleep and wakeup control
package cswc_pkg;

	// ****************************************************************
	// Channels and pins
	// ****************************************************************
	localparam int unsigned NCH     = 2;
	localparam logic        RX_IDLE = 1'h1;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam int unsigned OFF_W         = 8;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_CHAN_STAT = 8'h04;
	localparam logic [7:0]  OFF_WAKE_STAT = 8'h08;
	localparam logic [7:0]  OFF_WAKE_MASK = 8'h0C;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int unsigned CTRL_W         = 5;
	localparam int unsigned CTRL_RST_LSB   = 0;
	localparam int unsigned CTRL_SLEEP_LSB = 2;
	localparam int unsigned CTRL_SPLIT_BIT = 4;
	localparam logic [4:0]  CTRL_RESET     = 5'h03;

	// ****************************************************************
	// Wakeup status and mask fields
	// ****************************************************************
	localparam int unsigned WAKE_W      = 3;
	localparam int unsigned WAKE_SHARED = 0;
	localparam int unsigned WAKE_FIRST  = 1;
	localparam int unsigned WAKE_SECOND = 2;
	localparam logic [2:0]  WAKE_RESET  = 3'h0;
	localparam logic [2:0]  MASK_RESET  = 3'h0;

	// ****************************************************************
	// Channel status layout, one nibble per channel
	// ****************************************************************
	localparam int unsigned CHS_W       = 4;
	localparam int unsigned CHS_CLK_BIT = 2;
	localparam int unsigned CHS_RST_BIT = 3;

	typedef enum logic [1:0] {
		CH_RUN    = 2'b00,
		CH_RESET  = 2'b01,
		CH_SLEEP  = 2'b10,
		CH_CONFIG = 2'b11
	} cswc_chan_state_e;

endpackage

// File: cswc_chan_fsm.sv
// Per-channel reset, sleep and clock gating sequencer
`timescale 1ns/1ps
module cswc_chan_fsm (
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// Software requests
	input  wire logic                      rst_req,
	input  wire logic                      sleep_req,
	// Channel control
	output cswc_pkg::cswc_chan_state_e     state,
	output logic                           clk_en,
	output logic                           chan_rst_n
);

	cswc_pkg::cswc_chan_state_e state_r;
	cswc_pkg::cswc_chan_state_e state_nxt;
	logic                       clk_en_r;
	logic                       clk_en_nxt;
	logic                       rst_n_r;
	logic                       rst_n_nxt;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			cswc_pkg::CH_RUN: begin
				// Sleep while running is ignored: reset must come first
				if (rst_req) begin
					state_nxt = cswc_pkg::CH_RESET;
				end
			end
			cswc_pkg::CH_RESET: begin
				if (sleep_req) begin
					state_nxt = cswc_pkg::CH_SLEEP;
				end else if (!rst_req) begin
					state_nxt = cswc_pkg::CH_RUN;
				end
			end
			cswc_pkg::CH_SLEEP: begin
				if (!sleep_req) begin
					state_nxt = cswc_pkg::CH_CONFIG;
				end
			end
			cswc_pkg::CH_CONFIG: begin
				// Held in reset until software finishes reconfiguring
				if (sleep_req) begin
					state_nxt = cswc_pkg::CH_SLEEP;
				end else if (!rst_req) begin
					state_nxt = cswc_pkg::CH_RUN;
				end
			end
		endcase
		clk_en_nxt = (state_nxt != cswc_pkg::CH_SLEEP);
		rst_n_nxt  = (state_nxt == cswc_pkg::CH_RUN);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r  <= cswc_pkg::CH_RESET;
			clk_en_r <= 1'h1;
			rst_n_r  <= 1'h0;
		end else begin
			state_r  <= state_nxt;
			clk_en_r <= clk_en_nxt;
			rst_n_r  <= rst_n_nxt;
		end
	end

	assign state      = state_r;
	assign clk_en     = clk_en_r;
	assign chan_rst_n = rst_n_r;

endmodule // cswc_chan_fsm

// File: cswc_wake_edge.sv
// Falling edge detector on a CAN receive line, armed only while asleep
`timescale 1ns/1ps
module cswc_wake_edge (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Receive line and arming
	input  wire logic rx,
	input  wire logic armed,
	// Event
	output logic      fall
);

	logic rx_prev_r;
	logic rx_prev_nxt;

	always_comb begin
		rx_prev_nxt = rx;
	end

	// Idle level at reset so a low line at release counts as an edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_prev_r <= cswc_pkg::RX_IDLE;
		end else begin
			rx_prev_r <= rx_prev_nxt;
		end
	end

	assign fall = armed & rx_prev_r & ~rx;

endmodule // cswc_wake_edge

// File: cswc_top.sv
// CAN sleep and wakeup control with APB register slave
// Operation
// - Sleeping channel has its clock stopped
// - Receive falling edge while asleep raises wakeup
// - Wakeup forwarded only when its enable set
// - Default: one wakeup source for both channels
// - Select bit set gives per-channel wakeup
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module cswc_top #(
	parameter int unsigned ADDR_W = 8
) (
	// APB slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// CAN receive lines
	input  wire logic              can_rx_first,
	input  wire logic              can_rx_second,
	// Channel clock enables and resets
	output logic                   can_clk_en_first,
	output logic                   can_clk_en_second,
	output logic                   can_rst_n_first,
	output logic                   can_rst_n_second,
	// Interrupts
	output logic                   irq,
	output logic                   wake_irq_shared,
	output logic                   wake_irq_first,
	output logic                   wake_irq_second
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (ADDR_W < cswc_pkg::OFF_W) begin : g_bad_addr_w
		$error("ADDR_W too narrow for the register map");
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [cswc_pkg::CTRL_W-1:0] ctrl_r;
	logic [cswc_pkg::CTRL_W-1:0] ctrl_nxt;
	logic [cswc_pkg::WAKE_W-1:0] wake_r;
	logic [cswc_pkg::WAKE_W-1:0] wake_nxt;
	logic [cswc_pkg::WAKE_W-1:0] mask_r;
	logic [cswc_pkg::WAKE_W-1:0] mask_nxt;
	logic [cswc_pkg::WAKE_W-1:0] wake_set;
	logic [cswc_pkg::WAKE_W-1:0] wake_clr;
	logic [cswc_pkg::WAKE_W-1:0] pend_nxt;
	logic [cswc_pkg::WAKE_W-1:0] pend_r;
	logic [31:0]                 prdata_r;
	logic [31:0]                 prdata_nxt;
	logic                        err_r;
	logic                        err_nxt;
	logic                        setup;
	logic                        access;
	logic                        split;
	logic [cswc_pkg::NCH-1:0]    rx;
	logic [cswc_pkg::NCH-1:0]    fall;
	logic [cswc_pkg::NCH-1:0]    asleep;
	logic [cswc_pkg::NCH-1:0]    clk_en;
	logic [cswc_pkg::NCH-1:0]    rst_n;
	cswc_pkg::cswc_chan_state_e  st [cswc_pkg::NCH];

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		// Shift keeps the upper-bit test legal when ADDR_W equals the offset width
		hit = (a[cswc_pkg::OFF_W-1:0] == off) && ((a >> cswc_pkg::OFF_W) == '0);
	endfunction

	function automatic logic [3:0] chan_stat(input cswc_pkg::cswc_chan_state_e s,
		input logic ce, input logic rn);
		chan_stat = {~rn, ce, s};
	endfunction

	assign rx = {can_rx_second, can_rx_first};

	// ****************************************************************
	// Channels
	// ****************************************************************
	for (genvar i = 0; i < cswc_pkg::NCH; i++) begin : g_chan
		cswc_chan_fsm u_fsm (
			.pclk       (pclk),
			.presetn    (presetn),
			.rst_req    (ctrl_r[cswc_pkg::CTRL_RST_LSB+i]),
			.sleep_req  (ctrl_r[cswc_pkg::CTRL_SLEEP_LSB+i]),
			.state      (st[i]),
			.clk_en     (clk_en[i]),
			.chan_rst_n (rst_n[i])
		);
		assign asleep[i] = (st[i] == cswc_pkg::CH_SLEEP);
		cswc_wake_edge u_edge (
			.pclk    (pclk),
			.presetn (presetn),
			.rx      (rx[i]),
			.armed   (asleep[i]),
			.fall    (fall[i])
		);
	end

	assign can_clk_en_first  = clk_en[0];
	assign can_clk_en_second = clk_en[1];
	assign can_rst_n_first   = rst_n[0];
	assign can_rst_n_second  = rst_n[1];

	// ****************************************************************
	// APB register file and wakeup status
	// ****************************************************************
	// Read data is latched in the setup cycle, so every access
	// completes with no wait state.
	always_comb begin
		setup      = psel & ~penable;
		access     = psel & penable;
		split      = ctrl_r[cswc_pkg::CTRL_SPLIT_BIT];
		ctrl_nxt   = ctrl_r;
		mask_nxt   = mask_r;
		prdata_nxt = prdata_r;
		err_nxt    = err_r;
		wake_clr   = '0;
		wake_set   = '0;
		if (split) begin
			wake_set[cswc_pkg::WAKE_FIRST]  = fall[0];
			wake_set[cswc_pkg::WAKE_SECOND] = fall[1];
		end else begin
			wake_set[cswc_pkg::WAKE_SHARED] = |fall;
		end
		if (setup) begin
			err_nxt = ~(hit(paddr, cswc_pkg::OFF_CTRL) | hit(paddr, cswc_pkg::OFF_CHAN_STAT)
				| hit(paddr, cswc_pkg::OFF_WAKE_STAT) | hit(paddr, cswc_pkg::OFF_WAKE_MASK));
			prdata_nxt = 32'h0000_0000;
			if (!pwrite) begin
				if (hit(paddr, cswc_pkg::OFF_CTRL)) begin
					prdata_nxt[cswc_pkg::CTRL_W-1:0] = ctrl_r;
				end
				if (hit(paddr, cswc_pkg::OFF_CHAN_STAT)) begin
					prdata_nxt[2*cswc_pkg::CHS_W-1:0] = {chan_stat(st[1], clk_en[1], rst_n[1]),
						chan_stat(st[0], clk_en[0], rst_n[0])};
				end
				if (hit(paddr, cswc_pkg::OFF_WAKE_STAT)) begin
					prdata_nxt[cswc_pkg::WAKE_W-1:0] = wake_r;
				end
				if (hit(paddr, cswc_pkg::OFF_WAKE_MASK)) begin
					prdata_nxt[cswc_pkg::WAKE_W-1:0] = mask_r;
				end
			end
		end
		if (access && !err_r) begin
			if (pwrite && hit(paddr, cswc_pkg::OFF_CTRL)) begin
				ctrl_nxt = pwdata[cswc_pkg::CTRL_W-1:0];
			end
			if (pwrite && hit(paddr, cswc_pkg::OFF_WAKE_MASK)) begin
				mask_nxt = pwdata[cswc_pkg::WAKE_W-1:0];
			end
			// Clear only what was returned; later events survive
			if (!pwrite && hit(paddr, cswc_pkg::OFF_WAKE_STAT)) begin
				wake_clr = prdata_r[cswc_pkg::WAKE_W-1:0];
			end
		end
		wake_nxt = (wake_r & ~wake_clr) | wake_set;
		pend_nxt = wake_nxt & mask_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= cswc_pkg::CTRL_RESET;
			mask_r   <= cswc_pkg::MASK_RESET;
			wake_r   <= cswc_pkg::WAKE_RESET;
			pend_r   <= cswc_pkg::WAKE_RESET;
			prdata_r <= 32'h0000_0000;
			err_r    <= 1'h0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			mask_r   <= mask_nxt;
			wake_r   <= wake_nxt;
			pend_r   <= pend_nxt;
			prdata_r <= prdata_nxt;
			err_r    <= err_nxt;
		end
	end

	assign prdata          = prdata_r;
	assign pready          = 1'h1;
	assign pslverr         = psel & penable & err_r;
	assign irq             = |pend_r;
	assign wake_irq_shared = pend_r[cswc_pkg::WAKE_SHARED];
	assign wake_irq_first  = pend_r[cswc_pkg::WAKE_FIRST];
	assign wake_irq_second = pend_r[cswc_pkg::WAKE_SECOND];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sleep_clock_off: assert property (
		asleep[0] |-> !can_clk_en_first && !can_rst_n_first)
		else $error("first channel clocked while asleep");

	a_sleep_clock_off2: assert property (
		asleep[1] |-> !can_clk_en_second)
		else $error("second channel clocked while asleep");

	a_sleep_after_reset: assert property (
		$rose(asleep[0]) |-> $past(st[0]) inside {cswc_pkg::CH_RESET, cswc_pkg::CH_CONFIG})
		else $error("sleep entered without prior reset");

	a_run_ignores_sleep: assert property (
		(st[1] == cswc_pkg::CH_RUN && !ctrl_r[cswc_pkg::CTRL_RST_LSB+1]) |=> !asleep[1])
		else $error("running channel went to sleep");

	a_wake_edge_sets: assert property (
		(asleep[0] && can_rx_first ##1 asleep[0] && !can_rx_first)
		|=> (wake_r[cswc_pkg::WAKE_SHARED] || wake_r[cswc_pkg::WAKE_FIRST]))
		else $error("falling edge in sleep raised no wakeup");

	a_no_wake_awake: assert property (
		(!asleep[0] && !asleep[1]) |-> fall == '0)
		else $error("wakeup event while no channel sleeps");

	a_mask_gates_irq: assert property (
		(mask_r == '0) |-> ##1 ($past(mask_nxt) != '0 || !irq))
		else $error("interrupt raised with all enables clear");

	a_irq_follows: assert property (
		irq == |(wake_r & mask_r))
		else $error("interrupt output disagrees with status and mask");

	a_shared_mode: assert property (
		(!split && |fall) |=> wake_r[cswc_pkg::WAKE_SHARED] && !$rose(wake_r[cswc_pkg::WAKE_FIRST]))
		else $error("shared wakeup not raised");

	a_split_mode: assert property (
		(split && fall[1]) |=> wake_r[cswc_pkg::WAKE_SECOND] && !$rose(wake_r[cswc_pkg::WAKE_SHARED]))
		else $error("split wakeup not raised on its channel");

	a_wake_restart: assert property (
		(asleep[0] && !ctrl_r[cswc_pkg::CTRL_SLEEP_LSB]) |=> 
		st[0] == cswc_pkg::CH_CONFIG && can_clk_en_first && !can_rst_n_first)
		else $error("clock not restarted with reset held");

	a_read_clears: assert property (
		(access && !pwrite && !err_r && hit(paddr, cswc_pkg::OFF_WAKE_STAT) && fall == '0)
		|=> (wake_r & $past(prdata_r[cswc_pkg::WAKE_W-1:0])) == '0)
		else $error("status read did not clear");

	a_sleep_rst_second: assert property (
		asleep[1] |-> !can_rst_n_second)
		else $error("second channel out of reset while asleep");

	a_run_ignores_sleep0: assert property (
		(st[0] == cswc_pkg::CH_RUN && !ctrl_r[cswc_pkg::CTRL_RST_LSB]) |=> !asleep[0])
		else $error("running first channel went to sleep");

	a_wake_edge_sets2: assert property (
		(asleep[1] && can_rx_second ##1 asleep[1] && !can_rx_second)
		|=> (wake_r[cswc_pkg::WAKE_SHARED] || wake_r[cswc_pkg::WAKE_SECOND]))
		else $error("falling edge in sleep raised no wakeup on second channel");

	a_irq_needs_enable: assert property (
		irq |-> (mask_r != '0))
		else $error("interrupt raised with every enable clear");

	a_shared_second: assert property (
		(!split && fall[1]) |=> wake_r[cswc_pkg::WAKE_SHARED] && !$rose(wake_r[cswc_pkg::WAKE_SECOND]))
		else $error("shared wakeup not raised by second channel");

	a_split_first: assert property (
		(split && fall[0]) |=> wake_r[cswc_pkg::WAKE_FIRST] && !$rose(wake_r[cswc_pkg::WAKE_SHARED]))
		else $error("split wakeup not raised on first channel");

	a_wake_restart2: assert property (
		(asleep[1] && !ctrl_r[cswc_pkg::CTRL_SLEEP_LSB+1]) |=>
		st[1] == cswc_pkg::CH_CONFIG && can_clk_en_second && !can_rst_n_second)
		else $error("second clock not restarted with reset held");

	a_config_holds_rst: assert property (
		(st[0] == cswc_pkg::CH_CONFIG) |-> can_clk_en_first && !can_rst_n_first)
		else $error("first channel left reset before configuration");

	// Set must win over a read clear in the same cycle
	a_clear_keeps_set: assert property (
		(access && !pwrite && !err_r && hit(paddr, cswc_pkg::OFF_WAKE_STAT))
		|=> (wake_r & $past(wake_set)) == $past(wake_set))
		else $error("new wakeup lost to a status read");

	a_err_no_write: assert property (
		(access && pwrite && err_r) |=> ctrl_r == $past(ctrl_r) && mask_r == $past(mask_r))
		else $error("unmapped write changed a register");

	c_enter_sleep:  cover property (st[0] == cswc_pkg::CH_RESET ##1 asleep[0]);
	c_shared_wake:  cover property (!split && fall[0] ##1 irq);
	c_split_second: cover property (split && fall[1] ##1 wake_irq_second);
	c_back_to_run:  cover property (st[1] == cswc_pkg::CH_CONFIG ##1 st[1] == cswc_pkg::CH_RUN);
	c_split_first:  cover property (split && fall[0] ##1 wake_irq_first);

endmodule // cswc_top

// File: cswc_rx_model.sv
// Behavioural model of the two CAN receive lines seen by the wakeup logic
`timescale 1ns/1ps
module cswc_rx_model (
	// Clock
	input  wire logic pclk,
	// Receive lines
	output logic      rx_first,
	output logic      rx_second
);
	// Recessive level between frames
	initial begin
		rx_first = cswc_pkg::RX_IDLE;
		rx_second = cswc_pkg::RX_IDLE;
	end

	// Short dominant pulse, long enough to be sampled low three times
	task automatic pulse(input int ch);
		@(posedge pclk);
		if (ch == 0) rx_first <= ~cswc_pkg::RX_IDLE;
		else rx_second <= ~cswc_pkg::RX_IDLE;
		repeat (3) @(posedge pclk);
		rx_first <= cswc_pkg::RX_IDLE;
		rx_second <= cswc_pkg::RX_IDLE;
	endtask
endmodule // cswc_rx_model

// File: can_sleep_wakeup_control_bench.sv
// Self-checking bench of the CAN sleep and wakeup control
`timescale 1ns/1ps
module can_sleep_wakeup_control_bench;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] chs;
	} cswc_row_s;

	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, e, rx_first, rx_second;
	logic        clk_first, clk_second, rstn_first, rstn_second;
	logic        irq, wk_sh, wk_first, wk_second;
	int          comparisons, miscompares;
	cswc_row_s   rows [7];

	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	cswc_rx_model i_cswc_rx_model (.pclk(pclk), .rx_first(rx_first), .rx_second(rx_second));

	cswc_top #(.ADDR_W(8)) i_cswc_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.can_rx_first(rx_first), .can_rx_second(rx_second),
		.can_clk_en_first(clk_first), .can_clk_en_second(clk_second),
		.can_rst_n_first(rstn_first), .can_rst_n_second(rstn_second),
		.irq(irq), .wake_irq_shared(wk_sh), .wake_irq_first(wk_first),
		.wake_irq_second(wk_second)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 50) begin
			miscompares++;
			test_done();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic pins(input logic [31:0] cs);
		chk("pins", {28'h0, clk_second, clk_first, rstn_second, rstn_first},
			{28'h0, cs[6], cs[2], ~cs[7], ~cs[3]});
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		comparisons = 0;
		miscompares = 0;
		rows = '{'{32'h0F, 32'hAA}, '{32'h03, 32'hFF}, '{32'h00, 32'h44}, '{32'h0C, 32'h44},
			'{32'h05, 32'h4A}, '{32'h01, 32'h4F}, '{32'h00, 32'h44}};
		settle(2);
		pins(32'hDD);
		chk("pready", {31'h0, pready}, 32'h1);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cswc_pkg::OFF_CTRL, 32'h0);
		chk("ctrl reset", q, 32'h03);
		apb(1'b0, cswc_pkg::OFF_CHAN_STAT, 32'h0);
		chk("chan reset", q, 32'hDD);
		apb(1'b0, cswc_pkg::OFF_WAKE_MASK, 32'h0);
		chk("mask reset", q, 32'h0);
		$display("reset test done");

		// Sleep, reconfigure and run sequences
		foreach (rows[i]) begin
			apb(1'b1, cswc_pkg::OFF_CTRL, rows[i].ctrl);
			settle(3);
			apb(1'b0, cswc_pkg::OFF_CHAN_STAT, 32'h0);
			chk("chan stat", q, rows[i].chs);
			pins(rows[i].chs);
		end
		$display("row test done");

		// Shared then split wakeup with both channels asleep
		apb(1'b1, cswc_pkg::OFF_CTRL, 32'h0F);
		apb(1'b1, cswc_pkg::OFF_WAKE_MASK, 32'h7);
		for (int ch = 0; ch < 2; ch++) begin
			i_cswc_rx_model.pulse(ch);
			settle(2);
			chk("irq", {31'h0, irq}, 32'h1);
			chk("shared", {29'h0, wk_second, wk_first, wk_sh}, 32'h1);
			apb(1'b0, cswc_pkg::OFF_WAKE_STAT, 32'h0);
			chk("stat shared", q, 32'h1);
			settle(1);
			chk("irq clear", {31'h0, irq}, 32'h0);
		end
		apb(1'b1, cswc_pkg::OFF_CTRL, 32'h1F);
		for (int ch = 0; ch < 2; ch++) begin
			i_cswc_rx_model.pulse(ch);
			settle(2);
			chk("split", {29'h0, wk_second, wk_first, wk_sh}, 32'h2 << ch);
			apb(1'b0, cswc_pkg::OFF_WAKE_STAT, 32'h0);
			chk("stat split", q, 32'h2 << ch);
		end
		$display("wakeup test done");

		// Masked event stays pending until enabled
		apb(1'b1, cswc_pkg::OFF_WAKE_MASK, 32'h0);
		i_cswc_rx_model.pulse(0);
		settle(2);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, cswc_pkg::OFF_WAKE_MASK, 32'h2);
		settle(2);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		apb(1'b0, cswc_pkg::OFF_WAKE_STAT, 32'h0);
		chk("stat masked", q, 32'h2);

		// Edge on an awake channel is not a wakeup
		apb(1'b1, cswc_pkg::OFF_CTRL, 32'h10);
		settle(3);
		i_cswc_rx_model.pulse(0);
		settle(2);
		apb(1'b0, cswc_pkg::OFF_WAKE_STAT, 32'h0);
		chk("stat awake", q, 32'h0);
		$display("mask test done");

		// Unmapped and read-only places
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", q, 32'h0);
		apb(1'b1, 8'h10, 32'hFF);
		chk("unmapped wr err", {31'h0, e}, 32'h1);
		apb(1'b0, cswc_pkg::OFF_CTRL, 32'h0);
		chk("ctrl kept", q, 32'h10);
		apb(1'b1, cswc_pkg::OFF_CHAN_STAT, 32'hFF);
		chk("ro err", {31'h0, e}, 32'h0);
		settle(2);
		apb(1'b0, cswc_pkg::OFF_CHAN_STAT, 32'h0);
		chk("ro stat", q, 32'h44);

		// Reset in mid-run
		@(posedge pclk);
		presetn <= 1'b0;
		settle(2);
		pins(32'hDD);
		chk("irq reset", {31'h0, irq}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cswc_pkg::OFF_CTRL, 32'h0);
		chk("ctrl rereset", q, 32'h03);
		$display("error and reset test done");
		test_done();
	end
endmodule // can_sleep_wakeup_control_bench
